// ### core/pbg_map.svh
// Register addresses, bit positions and reset values of the port B block
`ifndef PBG_MAP_SVH
`define PBG_MAP_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define PBG_ADDR_PINS        8'h06
`define PBG_ADDR_OPTIONS     8'h81
`define PBG_ADDR_DIRECTION   8'h86
`define PBG_ADDR_INTCTL_LO   8'h0B
`define PBG_ADDR_INTCTL_HI   8'h8B

// ****************************************************************
// Field positions
// ****************************************************************
`define PBG_OPT_PULL_UP_DIS_N 7
`define PBG_OPT_EDGE_SEL      6
`define PBG_IC_GLOBAL_EN      7
`define PBG_IC_EXT_EN         4
`define PBG_IC_CHANGE_EN      3
`define PBG_IC_EXT_FLAG       1
`define PBG_IC_CHANGE_FLAG    0
`define PBG_EXT_PIN           0
`define PBG_CHG_LSB           4
`define PBG_CHG_MSB           7

// ****************************************************************
// Timing counts
// ****************************************************************
// Cycles after reset release until the edge history holds real pin samples
`define PBG_EDGE_SETTLE       3

// ****************************************************************
// Reset values
// ****************************************************************
`define PBG_RST_OPTIONS      8'hFF
`define PBG_RST_DIRECTION    8'hFF
`define PBG_RST_INTCTL       8'h00
`define PBG_RST_LATCH        4'h0
`define PBG_RST_OUT          8'h00
`define PBG_RST_RDATA        8'h00

`endif

// ### core/pbg_pkg.sv
// Types shared by the port B block
package pbg_pkg;

  // One register or port byte
  typedef logic [7:0] pbg_byte_t;

  // The four change-detect pins
  typedef logic [3:0] pbg_nib_t;

  // Register selected by the current bus address
  typedef enum logic [4:0] {
    PBG_SEL_NONE   = 5'b00001,
    PBG_SEL_PINS   = 5'b00010,
    PBG_SEL_OPT    = 5'b00100,
    PBG_SEL_DIR    = 5'b01000,
    PBG_SEL_INTCTL = 5'b10000
  } pbg_sel_e;

endpackage : pbg_pkg

// ### core/pbg_sync.sv
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps

module pbg_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  // ****************************************************************
  // Next values: the first stage feeds only the second
  // ****************************************************************
  always_comb begin
    nxt_meta = i_async;
    nxt_sync = meta_ff;
  end

  // Registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign o_sync = sync_ff;

endmodule : pbg_sync

// ### core/pbg_edge.sv
// Edge detector with selectable polarity for the external interrupt pin
`timescale 1ns/100ps

module pbg_edge (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_level,
  input  wire logic i_rising,
  output logic      o_pulse
);

  logic prev_ff;
  logic nxt_prev;

  // ****************************************************************
  // Previous level tracking
  // ****************************************************************
  always_comb begin
    nxt_prev = i_level;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= nxt_prev;
    end
  end

  // One-cycle pulse on the chosen edge; a change of polarity alone never fires
  assign o_pulse = i_rising ? (i_level & ~prev_ff) : (~i_level & prev_ff);

endmodule : pbg_edge

// ### core/pbg_top.sv
// Port B: bidirectional pins, pull-ups, change interrupt and external interrupt
//
// Functional notes
// - Direction bit one tristates the pin driver, making the pin an input.
// - Direction bit zero drives the pin from its output latch bit.
// - Pull-ups of all input pins are on while option bit 7 is zero.
// - A pin set as output always has its pull-up switched off.
// - Power-on reset loads options with all ones, so pull-ups start off.
// - Every reset sets all direction bits, so all pins start as inputs.
// - Only upper four input pins join change detection; outputs are excluded.
// - Each participating pin is compared with its value latched at last port read or write.
// - The four mismatches are ORed to set the change flag, control bit 0.
// - A pending enabled change interrupt can wake the device from sleep.
// - Any port read or write re-latches the comparison value, ending mismatch.
// - While mismatch persists the flag keeps setting; a clear does not last.
// - Lowest pin is an external interrupt, active edge chosen by option bit 6.
`timescale 1ns/100ps
`include "pbg_map.svh"

module pbg_top (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // Register port of the core
  input  wire logic [7:0] i_addr,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  // Port pins
  input  wire logic [7:0] i_pin,
  output logic      [7:0] o_pin,
  output logic      [7:0] o_pin_oe_n,
  output logic      [7:0] o_pull_up_en,
  // Interrupt and wake
  input  wire logic       i_sleep,
  output logic            o_port_change_irq,
  output logic            o_ext_irq,
  output logic            o_wake
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta_ff;
  logic rst_n_ff;
  logic nxt_rst_meta;
  logic nxt_rst_n;

  // Release ripples through both stages, so no register leaves reset mid-cycle
  always_comb begin
    nxt_rst_meta = 1'b1;
    nxt_rst_n    = rst_meta_ff;
  end

  // Asynchronous assert, two-stage synchronous release
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= nxt_rst_meta;
      rst_n_ff    <= nxt_rst_n;
    end
  end

  // ****************************************************************
  // Pin input synchronisation and external edge
  // ****************************************************************
  pbg_pkg::pbg_byte_t pin_s;
  logic               ext_edge;
  logic               ext_edge_raw;

  pbg_sync #(
    .WIDTH (8)
  ) u_pin_sync (
    .i_clk   (i_clk),
    .i_rst_n (rst_n_ff),
    .i_async (i_pin),
    .o_sync  (pin_s)
  );

  pbg_pkg::pbg_byte_t options_ff;

  pbg_edge u_ext_edge (
    .i_clk    (i_clk),
    .i_rst_n  (rst_n_ff),
    .i_level  (pin_s[`PBG_EXT_PIN]),
    .i_rising (options_ff[`PBG_OPT_EDGE_SEL]),
    .o_pulse  (ext_edge_raw)
  );

  logic [`PBG_EDGE_SETTLE-1:0] arm_ff;
  logic [`PBG_EDGE_SETTLE-1:0] nxt_arm;

  // Synchroniser and edge history leave reset at zero, not at the pin level;
  // without this guard a pin idling high would flag a false edge after each reset.
  // Trade-off: a real edge in the first cycles after reset is not reported.
  always_comb begin
    nxt_arm  = {arm_ff[`PBG_EDGE_SETTLE-2:0], 1'b1};
    ext_edge = ext_edge_raw & arm_ff[`PBG_EDGE_SETTLE-1];
  end

  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      arm_ff <= '0;
    end else begin
      arm_ff <= nxt_arm;
    end
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Decodes a bus address into the register it selects
  function automatic pbg_pkg::pbg_sel_e decode(input logic [7:0] addr);
    pbg_pkg::pbg_sel_e sel;
    sel = pbg_pkg::PBG_SEL_NONE;
    case (addr)
      `PBG_ADDR_PINS: begin
        sel = pbg_pkg::PBG_SEL_PINS;
      end
      `PBG_ADDR_OPTIONS: begin
        sel = pbg_pkg::PBG_SEL_OPT;
      end
      `PBG_ADDR_DIRECTION: begin
        sel = pbg_pkg::PBG_SEL_DIR;
      end
      `PBG_ADDR_INTCTL_LO, `PBG_ADDR_INTCTL_HI: begin
        sel = pbg_pkg::PBG_SEL_INTCTL;
      end
      default: begin
        sel = pbg_pkg::PBG_SEL_NONE;
      end
    endcase
    return sel;
  endfunction : decode

  pbg_pkg::pbg_sel_e sel;
  logic              wr_pins;
  logic              wr_opt;
  logic              wr_dir;
  logic              wr_ic;
  logic              rd_pins;

  // Strobes per register; unmapped addresses are ignored on write
  always_comb begin
    sel     = decode(i_addr);
    wr_pins = i_wr && (sel == pbg_pkg::PBG_SEL_PINS);
    wr_opt  = i_wr && (sel == pbg_pkg::PBG_SEL_OPT);
    wr_dir  = i_wr && (sel == pbg_pkg::PBG_SEL_DIR);
    wr_ic   = i_wr && (sel == pbg_pkg::PBG_SEL_INTCTL);
    rd_pins = i_rd && (sel == pbg_pkg::PBG_SEL_PINS);
  end

  // ****************************************************************
  // Option, direction and output latch registers
  // ****************************************************************
  pbg_pkg::pbg_byte_t direction_ff;
  pbg_pkg::pbg_byte_t out_latch_ff;
  pbg_pkg::pbg_byte_t nxt_options;
  pbg_pkg::pbg_byte_t nxt_direction;
  pbg_pkg::pbg_byte_t nxt_out_latch;

  // Output latch keeps its value while a pin is input, ready for a later switch
  always_comb begin
    nxt_options   = wr_opt  ? i_wdata : options_ff;
    nxt_direction = wr_dir  ? i_wdata : direction_ff;
    nxt_out_latch = wr_pins ? i_wdata : out_latch_ff;
  end

  // All resets load options and direction with ones
  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      options_ff   <= `PBG_RST_OPTIONS;
      direction_ff <= `PBG_RST_DIRECTION;
      out_latch_ff <= `PBG_RST_OUT;
    end else begin
      options_ff   <= nxt_options;
      direction_ff <= nxt_direction;
      out_latch_ff <= nxt_out_latch;
    end
  end

  // ****************************************************************
  // Pin drivers and pull-ups
  // ****************************************************************
  // Enable is low while driving; a set direction bit releases the pin
  assign o_pin_oe_n = direction_ff;
  assign o_pin      = out_latch_ff;

  // Shared pull-up control, masked off for every output pin
  always_comb begin
    o_pull_up_en = {8{~options_ff[`PBG_OPT_PULL_UP_DIS_N]}}
                 & direction_ff;
  end

  // ****************************************************************
  // Change detection on the upper pins
  // ****************************************************************
  pbg_pkg::pbg_nib_t last_read_ff;
  pbg_pkg::pbg_nib_t nxt_last_read;
  pbg_pkg::pbg_nib_t upper_change_pins;
  pbg_pkg::pbg_nib_t upper_inputs;
  logic              mismatch;

  // Output pins are masked out so that driving them never looks like a key press
  always_comb begin
    upper_change_pins = pin_s[`PBG_CHG_MSB:`PBG_CHG_LSB];
    upper_inputs      = direction_ff[`PBG_CHG_MSB:`PBG_CHG_LSB];
    mismatch          = |((upper_change_pins ^ last_read_ff) & upper_inputs);
  end

  // A read or a write of the port takes the present pin values as the new reference
  always_comb begin
    nxt_last_read = (rd_pins || wr_pins) ? upper_change_pins : last_read_ff;
  end

  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      last_read_ff <= `PBG_RST_LATCH;
    end else begin
      last_read_ff <= nxt_last_read;
    end
  end

  // ****************************************************************
  // Interrupt control register
  // ****************************************************************
  pbg_pkg::pbg_byte_t intctl_ff;
  pbg_pkg::pbg_byte_t nxt_intctl;

  // Software writes every bit; hardware events win over a clear in the same cycle.
  // The change flag is set anew on every cycle of a mismatch, so clearing it only
  // sticks after the port has been read or written (the service routine must read first).
  always_comb begin
    nxt_intctl = wr_ic ? i_wdata : intctl_ff;
    if (mismatch) begin
      nxt_intctl[`PBG_IC_CHANGE_FLAG] = 1'b1;
    end
    if (ext_edge) begin
      nxt_intctl[`PBG_IC_EXT_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      intctl_ff <= `PBG_RST_INTCTL;
    end else begin
      intctl_ff <= nxt_intctl;
    end
  end

  // ****************************************************************
  // Interrupt requests and wake
  // ****************************************************************
  logic change_pend;
  logic ext_pend;

  // Wake needs only the source enable: the core resumes even with global enable off
  always_comb begin
    change_pend       = intctl_ff[`PBG_IC_CHANGE_FLAG] & intctl_ff[`PBG_IC_CHANGE_EN];
    ext_pend          = intctl_ff[`PBG_IC_EXT_FLAG] & intctl_ff[`PBG_IC_EXT_EN];
    o_port_change_irq = change_pend & intctl_ff[`PBG_IC_GLOBAL_EN];
    o_ext_irq         = ext_pend & intctl_ff[`PBG_IC_GLOBAL_EN];
    o_wake            = i_sleep & (change_pend | ext_pend);
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  pbg_pkg::pbg_byte_t rdata_ff;
  pbg_pkg::pbg_byte_t nxt_rdata;

  // The port read returns pin levels; polling it re-latches the change reference
  always_comb begin
    nxt_rdata = rdata_ff;
    if (i_rd) begin
      case (sel)
        pbg_pkg::PBG_SEL_PINS: begin
          nxt_rdata = pin_s;
        end
        pbg_pkg::PBG_SEL_OPT: begin
          nxt_rdata = options_ff;
        end
        pbg_pkg::PBG_SEL_DIR: begin
          nxt_rdata = direction_ff;
        end
        pbg_pkg::PBG_SEL_INTCTL: begin
          nxt_rdata = intctl_ff;
        end
        default: begin
          nxt_rdata = `PBG_RST_RDATA;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rdata_ff <= `PBG_RST_RDATA;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_rdata = rdata_ff;

endmodule : pbg_top

// ### sim/pbg_top_assertions.sv
// Concurrent checker of the port B block, bound to its top module
`timescale 1ns/100ps
// ****
// Checker
// ****
module pbg_chk (
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  input  wire logic [7:0] i_addr,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_wdata,
  input  wire logic [7:0] o_rdata,
  input  wire logic [7:0] i_pin,
  input  wire logic [7:0] o_pin,
  input  wire logic [7:0] o_pin_oe_n,
  input  wire logic [7:0] o_pull_up_en,
  input  wire logic       i_sleep,
  input  wire logic       o_port_change_irq,
  input  wire logic       o_ext_irq,
  input  wire logic       o_wake
);
  logic chg_en_ff, ext_en_ff, rise_ff;
  logic nxt_chg_en, nxt_ext_en, nxt_rise;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  // Shadow of the enables and edge select, taken from bus writes only
  always_comb begin
    nxt_chg_en = chg_en_ff;
    nxt_ext_en = ext_en_ff;
    nxt_rise   = rise_ff;
    if (i_wr && i_addr[6:0] == 7'h0B) begin
      nxt_chg_en = i_wdata[7] & i_wdata[3];
      nxt_ext_en = i_wdata[7] & i_wdata[4];
    end
    if (i_wr && i_addr == 8'h81) begin
      nxt_rise = i_wdata[6];
    end
  end
  // Shadow registers, reset like the block's own
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      chg_en_ff <= 1'b0;
      ext_en_ff <= 1'b0;
      rise_ff   <= 1'b1;
    end else begin
      chg_en_ff <= nxt_chg_en;
      ext_en_ff <= nxt_ext_en;
      rise_ff   <= nxt_rise;
    end
  end
  // A quiet bus keeps the flags from being cleared while we wait
  sequence s_quiet;
    (!i_wr && !i_rd) [*5];
  endsequence
  sequence s_upper_change;
    $stable(i_pin) [*3] ##1 (chg_en_ff && $changed(i_pin[7:4] & o_pin_oe_n[7:4]));
  endsequence
  sequence s_ext_edge;
    ext_en_ff && (rise_ff ? $rose(i_pin[0]) : $fell(i_pin[0]));
  endsequence
  AST_DIR_WRITE: assert property (i_wr && i_addr == 8'h86 |=> o_pin_oe_n == $past(i_wdata))
    else $error("direction write not on drivers");
  AST_OUT_WRITE: assert property (i_wr && i_addr == 8'h06 |=> o_pin == $past(i_wdata))
    else $error("port write not on pins");
  AST_PULL_WRITE: assert property (i_wr && i_addr == 8'h81 |=>
    o_pull_up_en == ({8{~$past(i_wdata[7])}} & o_pin_oe_n)) else $error("pull-up control wrong");
  AST_OUT_NO_PULL: assert property ((o_pull_up_en & ~o_pin_oe_n) == 8'h00)
    else $error("pull-up on a driven pin");
  AST_RESET_STATE: assert property ($rose(i_resetn) |-> o_pin_oe_n == 8'hFF && o_pull_up_en == 8'h00)
    else $error("bad state out of reset");
  AST_READ_PINS: assert property ($stable(i_pin) [*3] ##0 (i_rd && i_addr == 8'h06) |=> o_rdata == $past(i_pin))
    else $error("port read wrong");
  AST_CHANGE_SET: assert property (s_upper_change ##0 s_quiet |-> o_port_change_irq)
    else $error("upper pin change not flagged");
  AST_CHANGE_GATE: assert property (!chg_en_ff |-> !o_port_change_irq)
    else $error("change request while disabled");
  AST_WAKE: assert property (i_sleep && (o_port_change_irq || o_ext_irq) |-> o_wake)
    else $error("no wake from sleep");
  AST_EXT_EDGE: assert property (s_ext_edge ##0 (!i_wr) [*5] |-> o_ext_irq)
    else $error("external edge not flagged");
endmodule : pbg_chk

bind pbg_top pbg_chk u_chk (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
  .i_wdata(i_wdata), .o_rdata(o_rdata), .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n),
  .o_pull_up_en(o_pull_up_en), .i_sleep(i_sleep), .o_port_change_irq(o_port_change_irq),
  .o_ext_irq(o_ext_irq), .o_wake(o_wake));

// ### sim/pbg_board.sv
// Board model at the port pins: keys, pull-ups and floating lines
`timescale 1ns/100ps
module pbg_board (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe_n,
  input  wire logic [7:0] i_pull_up_en,
  input  wire logic [7:0] i_key_drv,
  input  wire logic [7:0] i_key_val,
  output logic      [7:0] o_level
);
  logic [7:0] float_ff = 8'h5A;
  // Undriven lines wander, so nothing leans on a settled unknown
  always_ff @(posedge i_clk) begin
    float_ff <= ~float_ff;
  end
  // Core driver wins, then keys, then the weak pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!i_oe_n[i]) begin
        o_level[i] = i_out[i];
      end else if (i_key_drv[i]) begin
        o_level[i] = i_key_val[i];
      end else if (i_pull_up_en[i]) begin
        o_level[i] = 1'b1;
      end else begin
        o_level[i] = float_ff[i];
      end
    end
  end
endmodule : pbg_board

// ### sim/port_b_gpio_change_irq_test.sv
// Self-checking bench of the port B block
`timescale 1ns/100ps
module port_b_gpio_change_irq_test;
  logic       i_clk = 1'b0;
  logic       i_resetn = 1'b0;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic       i_sleep = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] key_drv = 8'hFF;
  logic [7:0] key_val = 8'h00;
  logic [7:0] o_rdata, o_pin, o_pin_oe_n, o_pull_up_en, pin_lvl;
  logic       o_port_change_irq, o_ext_irq, o_wake;
  int         fails = 0;
  int         samples_checked = 0;
  // ****
  // Clock, design and board
  // ****
  always #5 i_clk = ~i_clk;
  pbg_top u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_pin(pin_lvl), .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n),
    .o_pull_up_en(o_pull_up_en), .i_sleep(i_sleep), .o_port_change_irq(o_port_change_irq),
    .o_ext_irq(o_ext_irq), .o_wake(o_wake));
  pbg_board u_board (.i_clk(i_clk), .i_out(o_pin), .i_oe_n(o_pin_oe_n), .i_pull_up_en(o_pull_up_en),
    .i_key_drv(key_drv), .i_key_val(key_val), .o_level(pin_lvl));
  // Compare one byte, four-state exact
  task automatic ck(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : ck
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc
  // Bus strobes change on the falling edge, one cycle each
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(negedge i_clk);
    i_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_clk);
    i_addr = a;
    i_rd = 1'b1;
    @(negedge i_clk);
    i_rd = 1'b0;
    ck(o_rdata, exp);
  endtask : rd
  task automatic summarize;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  // Whole run is under 130 cycles; this is about 40 times that
  initial begin
    #50us;
    fails++;
    summarize();
  end
  // Main sequence
  initial begin
    repeat (6) @(negedge i_clk);
    i_resetn = 1'b1;
    cyc(4);
    ck(o_pin_oe_n, 8'hFF);
    ck(o_pull_up_en, 8'h00);
    rd(8'h81, 8'hFF);
    wr(8'h07, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h86, 8'hFF);
    rd(8'h8B, 8'h00);
    // Pull-ups on, upper nibble driven; outputs must not flag a change
    wr(8'h81, 8'h7F);
    wr(8'h06, 8'hA5);
    wr(8'h86, 8'h0F);
    key_drv = 8'h0F;
    ck(o_pull_up_en, 8'h0F);
    ck(o_pin_oe_n, 8'h0F);
    ck(o_pin, 8'hA5);
    cyc(3);
    rd(8'h06, 8'hA0);
    rd(8'h8B, 8'h00);
    wr(8'h86, 8'hFF);
    key_drv = 8'h00;
    cyc(3);
    rd(8'h06, 8'hFF);
    // Change detection: lower pins ignored, flag sticks while mismatched
    wr(8'h81, 8'hFF);
    key_drv = 8'hFF;
    cyc(3);
    rd(8'h06, 8'h00);
    wr(8'h8B, 8'h88);
    key_val = 8'h0E;
    cyc(6);
    rd(8'h8B, 8'h88);
    key_val = 8'h1E;
    cyc(6);
    ck(8'(o_port_change_irq), 8'h01);
    i_sleep = 1'b1;
    cyc(1);
    ck(8'(o_wake), 8'h01);
    i_sleep = 1'b0;
    wr(8'h8B, 8'h88);
    cyc(2);
    ck(8'(o_port_change_irq), 8'h01);
    rd(8'h06, 8'h1E);
    wr(8'h8B, 8'h88);
    ck(8'(o_port_change_irq), 8'h00);
    key_val = 8'h3E;
    cyc(4);
    wr(8'h8B, 8'h08);
    ck(8'(o_port_change_irq), 8'h00);
    i_sleep = 1'b1;
    cyc(1);
    ck(8'(o_wake), 8'h01);
    i_sleep = 1'b0;
    rd(8'h0B, 8'h09);
    rd(8'h06, 8'h3E);
    // External pin: falling select, then rising select
    for (int i = 0; i < 2; i++) begin
      wr(8'h81, i ? 8'hFF : 8'hBF);
      wr(8'h8B, 8'h90);
      key_val[0] = 1'b1;
      cyc(6);
      ck(8'(o_ext_irq), 8'(i));
      key_val[0] = 1'b0;
      cyc(6);
      ck(8'(o_ext_irq), 8'h01);
    end
    // Second reset in mid-run
    key_drv = 8'h00;
    wr(8'h86, 8'h00);
    wr(8'h81, 8'h3F);
    i_resetn = 1'b0;
    cyc(1);
    ck(o_pin_oe_n, 8'hFF);
    ck(o_pull_up_en, 8'h00);
    i_resetn = 1'b1;
    cyc(4);
    rd(8'h81, 8'hFF);
    summarize();
  end
endmodule : port_b_gpio_change_irq_test
